// *** rtl/task_dispatch_pkg.sv ***
/*
 Shared types and constants for the task dispatch scheduler.
 Assumes one controller clock; priority values are small-is-urgent.
*/
package task_dispatch_pkg;

   // ***************************************************
   // Task numbering and widths
   // ***************************************************
   localparam int NUM_TASKS = 24;
   localparam int CLASS_SIZE = 8;
   localparam int CYC_BASE = 0;   // Cyclic tasks 0..7
   localparam int EXT_BASE = 8;   // External-input tasks 8..15
   localparam int DEV_BASE = 16;  // Internal-device tasks 16..23
   localparam int TASK_W = 5;
   localparam int PRIO_W = 8;
   localparam int STAMP_W = 16;
   localparam int DEPTH_W = 5;

   typedef logic [TASK_W-1:0] task_num_t;
   typedef logic [PRIO_W-1:0] prio_t;
   typedef logic [STAMP_W-1:0] stamp_t;
   typedef logic [DEPTH_W-1:0] depth_t;

   // ***************************************************
   // Configuration and carriers
   // ***************************************************
   typedef enum logic [2:0] {
      COND_NONE = 3'h0,
      COND_RISE = 3'h1,
      COND_FALL = 3'h2,
      COND_BOTH = 3'h3,
      COND_ON = 3'h4,
      COND_OFF = 3'h5
   } dev_cond_t;

   typedef prio_t [NUM_TASKS-1:0] prio_cfg_t;
   typedef dev_cond_t [CLASS_SIZE-1:0] dev_cfg_t;

   typedef struct packed {
      logic [CLASS_SIZE-1:0] ext;   // One-cycle requests, task 8+i
      logic [CLASS_SIZE-1:0] cyc;   // One-cycle requests, task i
   } task_req_t;

   typedef struct packed {
      logic [NUM_TASKS-1:0] pending;
      logic scan_start;             // One-cycle pulse: new scan begins
      logic scan_run;               // Scan program may execute
      task_num_t num;               // Running task number
      logic valid;                  // A task program is running
   } task_status_t;

   typedef enum logic {PH_SCAN, PH_DRAIN} phase_t;

endpackage : task_dispatch_pkg

// *** rtl/task_dispatch_scheduler.sv ***
/*
 Task dispatch scheduler: decides whether the scan program or a task
 program runs. Assumes the sequencer pulses SCAN_DONE when the scan
 program reaches its end and TASK_DONE when the running task returns.
*/
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - Task numbers: cyclic 0-7, external input 8-15, internal device 16-23.
// - Device tasks trigger on rising, falling, either edge, level on or off.
// - Device conditions checked only at scan end, started by priority.
// - Device triggers during scan or tasks wait until scan end.
// - A device condition gone before the scan-end check runs nothing.
// - Simultaneous requests: lower priority value runs first, other pends.
// - Standby task starts when the winner ends, before scan resumes.
// - Cyclic or input request suspends scan program, which resumes later.
// - Higher-priority cyclic task suspends a device task, which then resumes.
// - Requests for a running or waiting task are discarded.
// - Next scan starts once scan-end device tasks and preemptors finish.
// - Disable instruction blocks task insertion into scan; enable lifts it.
// - Equal-priority waiting tasks run in order of request.
// - Requests accepted only in run mode, ignored in stop mode.
module task_dispatch_scheduler (
   input wire logic SYS_CLK,
   input wire logic RESET,
   input wire logic RUN_MODE,
   input wire task_dispatch_pkg::task_req_t REQ,
   input wire logic [task_dispatch_pkg::CLASS_SIZE-1:0] DEV_BIT,
   input wire task_dispatch_pkg::prio_cfg_t TASK_PRIO,
   input wire task_dispatch_pkg::dev_cfg_t DEV_COND,
   input wire logic SCAN_DONE,
   input wire logic TASK_DONE,
   input wire logic TASK_START_DISABLE_INSTR,
   input wire logic TASK_START_ENABLE_INSTR,
   output var task_dispatch_pkg::task_status_t STATUS
);
   import task_dispatch_pkg::*;

   // ***************************************************
   // State
   // ***************************************************
   typedef struct packed {
      phase_t phase;
      logic disabled;
      logic [NUM_TASKS-1:0] pend;
      stamp_t [NUM_TASKS-1:0] stamp;
      stamp_t seq;
      depth_t depth;
      task_num_t [NUM_TASKS-1:0] stack;
      logic [CLASS_SIZE-1:0] prev;
      task_status_t status;
   } state_t;

   state_t st_q;
   state_t st_d;

   // ***************************************************
   // Functions
   // ***************************************************
   // Trigger test of one monitored bit against its last scan-end sample
   function automatic logic dev_trigger(input dev_cond_t c,
                                        input logic now_v,
                                        input logic old_v);
      logic hit;
      hit = 1'b0;
      unique case (c)
         COND_RISE: hit = now_v & ~old_v;
         COND_FALL: hit = ~now_v & old_v;
         COND_BOTH: hit = now_v ^ old_v;
         COND_ON: hit = now_v;
         COND_OFF: hit = ~now_v;
         default: hit = 1'b0;
      endcase
      return hit;
   endfunction : dev_trigger

   // Index of the entry below the given stack depth
   function automatic logic [DEPTH_W-1:0] below(input depth_t d);
      return DEPTH_W'(d - depth_t'(1));
   endfunction : below

   // Task number of a loop index
   function automatic task_num_t task_id(input int i);
      return TASK_W'(i);
   endfunction : task_id

   // ***************************************************
   // Next state
   // ***************************************************
   always_comb begin
      logic [NUM_TASKS-1:0] newreq;
      logic [NUM_TASKS-1:0] busy;
      logic [NUM_TASKS-1:0] accept;
      logic found;
      task_num_t best;
      prio_t top_prio;
      logic allow;
      logic push;
      newreq = '0;
      busy = '0;
      accept = '0;
      found = 1'b0;
      best = '0;
      top_prio = '0;
      allow = 1'b0;
      push = 1'b0;
      st_d = st_q;
      st_d.status.scan_start = 1'b0;

      // Cyclic and external requests land in their numbered slots
      newreq[CYC_BASE +: CLASS_SIZE] = REQ.cyc;
      newreq[EXT_BASE +: CLASS_SIZE] = REQ.ext;

      // Device conditions sampled only at the end of the scan program
      if (SCAN_DONE && st_q.phase == PH_SCAN && st_q.depth == '0 &&
          RUN_MODE) begin
         for (int i = 0; i < CLASS_SIZE; i++) begin
            newreq[DEV_BASE + i] = dev_trigger(DEV_COND[i], DEV_BIT[i],
                                               st_q.prev[i]);
         end
         st_d.prev = DEV_BIT;
         st_d.phase = PH_DRAIN;
      end

      // Stop mode ignores every request
      if (!RUN_MODE) begin
         newreq = '0;
      end

      // Tasks already waiting or running (stacked) drop repeats
      busy = st_q.pend;
      for (int k = 0; k < NUM_TASKS; k++) begin
         if (DEPTH_W'(k) < st_q.depth) begin
            busy[st_q.stack[k]] = 1'b1;
         end
      end
      accept = newreq & ~busy;
      for (int i = 0; i < NUM_TASKS; i++) begin
         if (accept[i]) begin
            st_d.pend[i] = 1'b1;
            st_d.stamp[i] = st_q.seq;
         end
      end
      if (|accept) begin
         st_d.seq = STAMP_W'(st_q.seq + stamp_t'(1));
      end

      // Finished task returns to whatever it interrupted
      if (TASK_DONE && st_q.depth != '0) begin
         st_d.depth = below(st_q.depth);
      end

      // Best waiting task: lowest priority value, then oldest request;
      // the ascending loop keeps the lowest task number on a full tie
      for (int i = 0; i < NUM_TASKS; i++) begin
         if (st_q.pend[i]) begin
            if (!found || TASK_PRIO[i] < TASK_PRIO[best]) begin
               found = 1'b1;
               best = task_id(i);
            end else if (TASK_PRIO[i] == TASK_PRIO[best] &&
                         st_q.stamp[i] < st_q.stamp[best]) begin
               best = task_id(i);
            end
         end
      end

      // Preempt only a strictly less urgent context; scan is least urgent
      if (st_d.depth == '0) begin
         allow = !(st_q.disabled && st_q.phase == PH_SCAN);
      end else begin
         top_prio = TASK_PRIO[st_q.stack[below(st_d.depth)]];
         allow = TASK_PRIO[best] < top_prio;
      end
      push = found && allow;
      if (push) begin
         st_d.stack[st_d.depth] = best;
         st_d.depth = DEPTH_W'(st_d.depth + depth_t'(1));
         st_d.pend[best] = 1'b0;
      end

      // Disable and enable instructions; enable wins if both arrive
      if (TASK_START_DISABLE_INSTR) begin
         st_d.disabled = 1'b1;
      end
      if (TASK_START_ENABLE_INSTR) begin
         st_d.disabled = 1'b0;
      end

      // New scan once all scan-end device work has drained
      if (st_q.phase == PH_DRAIN && st_d.depth == '0 && !push &&
          st_d.pend[DEV_BASE +: CLASS_SIZE] == '0) begin
         st_d.phase = PH_SCAN;
         st_d.status.scan_start = 1'b1;
      end

      // Registered outputs
      st_d.status.valid = st_d.depth != '0;
      // Idle number reads zero; below(0) would point past the stack
      if (st_d.depth != '0) begin
         st_d.status.num = st_d.stack[below(st_d.depth)];
      end else begin
         st_d.status.num = '0;
      end
      st_d.status.scan_run = st_d.phase == PH_SCAN && st_d.depth == '0;
      st_d.status.pending = st_d.pend;
   end

   // ***************************************************
   // State register
   // ***************************************************
   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign STATUS = st_q.status;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (RESET);

   sequence end_of_scan;
      SCAN_DONE && RUN_MODE && st_q.phase == PH_SCAN && st_q.depth == '0;
   endsequence

   sequence drain_entered;
      st_q.phase == PH_DRAIN;
   endsequence

   AST_DEV_AT_SCAN_END: assert property (
      end_of_scan |=> drain_entered)
      else $error("Scan end did not start device task check");

   AST_DEV_ONLY_AT_END: assert property (
      |(st_q.pend[DEV_BASE +: CLASS_SIZE] &
        ~$past(st_q.pend[DEV_BASE +: CLASS_SIZE])) |-> $past(SCAN_DONE))
      else $error("Device task queued away from scan end");

   AST_STOP_IGNORES: assert property (
      !RUN_MODE |=> (st_q.pend & ~$past(st_q.pend)) == '0)
      else $error("Request accepted in stop mode");

   AST_DROP_RUNNING: assert property (
      RUN_MODE && STATUS.valid && STATUS.num == task_num_t'(CYC_BASE) &&
      REQ.cyc[0] |=> !st_q.pend[CYC_BASE])
      else $error("Request for running task was queued");

   AST_PREEMPT_HIGHER: assert property (
      $past(st_q.depth) != '0 && st_q.depth > $past(st_q.depth) |->
      TASK_PRIO[STATUS.num] < $past(TASK_PRIO[STATUS.num]))
      else $error("Task preempted by a less urgent one");

   sequence scan_ready_with_work;
      STATUS.scan_run && !st_q.disabled &&
      |STATUS.pending[EXT_BASE + CLASS_SIZE - 1 : CYC_BASE];
   endsequence

   sequence task_running;
      STATUS.valid && !STATUS.scan_run;
   endsequence

   // A waiting cyclic or input task stops the scan on the next edge
   AST_SCAN_EXCLUSIVE: assert property (
      scan_ready_with_work |=> task_running)
      else $error("Scan program kept running over a waiting task");

   // A new scan only follows a drained scan end
   AST_NEXT_SCAN: assert property (
      STATUS.scan_start |-> $past(st_q.phase) == PH_DRAIN &&
      st_q.depth == '0 && st_q.pend[DEV_BASE +: CLASS_SIZE] == '0)
      else $error("Scan restarted with device work outstanding");

   sequence task_finishing_nested;
      TASK_DONE && st_q.depth > depth_t'(1);
   endsequence

   // Finishing a nested task hands the CPU back to another task
   AST_RESUME_BELOW: assert property (
      task_finishing_nested |=> STATUS.valid &&
      STATUS.num != $past(STATUS.num))
      else $error("Interrupted task not resumed");

   // Enable wins over disable when both instructions arrive together
   AST_FLAG_FOLLOWS: assert property (
      TASK_START_DISABLE_INSTR || TASK_START_ENABLE_INSTR |=>
      st_q.disabled == !$past(TASK_START_ENABLE_INSTR))
      else $error("Start-disable flag missed an instruction");

   AST_DISABLE_HOLDS: assert property (
      st_q.disabled && st_q.phase == PH_SCAN && st_q.depth == '0 &&
      !TASK_DONE |=> st_q.depth == '0)
      else $error("Task inserted while starts disabled");

   AST_STANDBY_FIRST: assert property (
      TASK_DONE && st_q.depth == depth_t'(1) && st_q.phase == PH_SCAN &&
      !st_q.disabled && st_q.pend != '0 |=> STATUS.valid)
      else $error("Scan resumed ahead of a standby task");

endmodule : task_dispatch_scheduler

`default_nettype wire

// *** tb/io_partner.sv ***
/*
 Far-side model: external input pins and monitored device bits.
 Assumes the bench changes its commands on the falling clock edge.
*/
`timescale 1ns/100ps
`default_nettype none

module io_partner
   import task_dispatch_pkg::*;
(
   input wire logic clk,
   input wire logic [7:0] cyc_cmd,
   input wire logic [7:0] ext_cmd,
   input wire logic [7:0] lvl_cmd,
   output task_req_t req,
   output logic [7:0] dev_bit
);
   // Pins follow commands one falling edge later
   always @(negedge clk) begin
      req <= '{ext: ext_cmd, cyc: cyc_cmd};
      dev_bit <= lvl_cmd;
   end
endmodule : io_partner

`default_nettype wire

// *** tb/tb_task_dispatch_scheduler.sv ***
/*
 Self-checking bench for the task dispatch scheduler.
 Assumes the io_partner model and the package are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module tb_task_dispatch_scheduler;
   import task_dispatch_pkg::*;
   logic clk = 0, rst = 1, run = 1, sdone = 0, tdone = 0, dis = 0, en = 0;
   logic [7:0] cyc_cmd = 0, ext_cmd = 0, lvl_cmd = 0, dev_bit;
   task_req_t req;
   prio_cfg_t prio;
   dev_cfg_t cond;
   task_status_t st;
   int num_errors = 0, n_checks = 0, cycles = 0;

   // ***************************************************
   // Clock, timeout and instances
   // ***************************************************
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         num_errors++;
         stop_test();
      end
   end
   io_partner io_partner_inst (.clk(clk), .cyc_cmd(cyc_cmd),
      .ext_cmd(ext_cmd), .lvl_cmd(lvl_cmd), .req(req), .dev_bit(dev_bit));
   task_dispatch_scheduler task_dispatch_scheduler_inst (.SYS_CLK(clk),
      .RESET(rst), .RUN_MODE(run), .REQ(req), .DEV_BIT(dev_bit),
      .TASK_PRIO(prio), .DEV_COND(cond), .SCAN_DONE(sdone),
      .TASK_DONE(tdone), .TASK_START_DISABLE_INSTR(dis),
      .TASK_START_ENABLE_INSTR(en), .STATUS(st));

   // ***************************************************
   // Shared drivers
   // ***************************************************
   task stop_test();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // One-cycle pulse: 0 task done, 1 scan done, 2 disable, 3 enable
   task pulse_in(input int k);
      @(negedge clk);
      case (k)
         0: tdone = 1;
         1: sdone = 1;
         2: dis = 1;
         default: en = 1;
      endcase
      @(negedge clk);
      {tdone, sdone, dis, en} = 4'h0;
   endtask : pulse_in
   task req_pulse(input logic [7:0] c, input logic [7:0] e);
      @(negedge clk);
      cyc_cmd <= c;
      ext_cmd <= e;
      @(negedge clk);
      cyc_cmd <= 8'h00;
      ext_cmd <= 8'h00;
   endtask : req_pulse
   task idle(input int n);
      repeat (n) @(negedge clk);
   endtask : idle
   // Bounded wait for a running task, then its number
   task wait_run(input task_num_t n);
      for (int i = 0; i < 12 && !(st.valid === 1'b1 && st.num === n); i++)
         @(negedge clk);
      `CHK("valid", 1'b1, st.valid)
      `CHK("num", n, st.num)
   endtask : wait_run

   // ***************************************************
   // Scenarios
   // ***************************************************
   task t_preempt();
      req_pulse(8'h01, 8'h00);
      wait_run(5'h00);
      `CHK("scan_run", 1'b0, st.scan_run)
      req_pulse(8'h01, 8'h00);
      idle(3);
      `CHK("pending0", 1'b0, st.pending[0])
      pulse_in(0);
      `CHK("valid", 1'b0, st.valid)
      `CHK("scan_run", 1'b1, st.scan_run)
   endtask : t_preempt
   task t_arb();
      req_pulse(8'h01, 8'h01);
      wait_run(5'h08);
      `CHK("pending0", 1'b1, st.pending[0])
      pulse_in(0);
      `CHK("scan_run", 1'b0, st.scan_run)
      `CHK("num", 5'h00, st.num)
      pulse_in(0);
   endtask : t_arb
   task t_dev();
      lvl_cmd <= 8'h01;
      idle(4);
      `CHK("valid", 1'b0, st.valid)
      `CHK("pending16", 1'b0, st.pending[16])
      pulse_in(1);
      wait_run(5'h10);
      req_pulse(8'h01, 8'h00);
      wait_run(5'h00);
      pulse_in(0);
      wait_run(5'h10);
      pulse_in(0);
      for (int i = 0; i < 6 && st.scan_start !== 1'b1; i++) @(negedge clk);
      `CHK("scan_start", 1'b1, st.scan_start)
   endtask : t_dev
   task t_glitch();
      lvl_cmd <= 8'h03;
      idle(3);
      lvl_cmd <= 8'h01;
      idle(2);
      pulse_in(1);
      idle(4);
      `CHK("pending17", 1'b0, st.pending[17])
      `CHK("valid", 1'b0, st.valid)
   endtask : t_glitch
   task t_conds();
      cond[2] = COND_FALL;
      cond[3] = COND_BOTH;
      cond[4] = COND_ON;
      cond[5] = COND_OFF;
      lvl_cmd <= 8'h25;
      idle(2);
      pulse_in(1);
      lvl_cmd <= 8'h19;
      idle(2);
      pulse_in(1);
      `CHK("pending_dev", 4'hf, st.pending[21:18])
      wait_run(5'h12);
      pulse_in(0);
      wait_run(5'h13);
      pulse_in(0);
      wait_run(5'h14);
      pulse_in(0);
      wait_run(5'h15);
      pulse_in(0);
   endtask : t_conds
   task t_stop();
      run = 0;
      req_pulse(8'h02, 8'h00);
      idle(4);
      `CHK("pending1", 1'b0, st.pending[1])
      run = 1;
   endtask : t_stop
   task t_disable();
      pulse_in(2);
      req_pulse(8'h02, 8'h00);
      idle(4);
      `CHK("valid", 1'b0, st.valid)
      `CHK("pending1", 1'b1, st.pending[1])
      req_pulse(8'h01, 8'h00);
      pulse_in(3);
      wait_run(5'h01);
      pulse_in(0);
      wait_run(5'h00);
      pulse_in(0);
   endtask : t_disable

   // ***************************************************
   // Main sequence
   // ***************************************************
   initial begin
      for (int i = 0; i < NUM_TASKS; i++) prio[i] = 8'h0a;
      for (int i = 0; i < CLASS_SIZE; i++) cond[i] = COND_NONE;
      {prio[0], prio[1], prio[8]} = {8'h03, 8'h03, 8'h02};
      {prio[16], prio[17]} = {8'h05, 8'h05};
      {cond[0], cond[1]} = {COND_RISE, COND_RISE};
      idle(8);
      rst = 0;
      idle(2);
      `CHK("scan_run", 1'b1, st.scan_run)
      t_preempt();
      t_arb();
      t_dev();
      t_glitch();
      t_conds();
      t_stop();
      t_disable();
      stop_test();
   end
endmodule : tb_task_dispatch_scheduler

`default_nettype wire
